// [hw/spc_ctrl.sv]
`timescale 1ns/10ps
// Self-programming controller: control register, windows, flash ops
module spc_ctrl #(
  parameter int PTR_W = 16, // Address pointer width
  parameter int AW    = 6   // Page buffer word index width
) (
  input  wire logic                  i_clk,        // 50 MHz clock
  input  wire logic                  i_sys_rst,    // Sync reset, high
  input  wire logic                  i_clk_en,     // Freezes state when low
  input  wire logic [7:0]            i_reg_addr,   // Register address
  input  wire logic [7:0]            i_reg_wdata,  // Register write data
  input  wire logic                  i_reg_wr,     // Write strobe
  input  wire logic                  i_reg_rd,     // Read strobe
  output logic      [7:0]            o_reg_rdata,  // Read data, next cycle
  input  wire logic                  i_store_req,  // Store instruction issued
  input  wire logic                  i_load_req,   // Load instruction issued
  input  wire logic [PTR_W-1:0]      i_ptr,        // Address pointer
  input  wire logic [15:0]           i_data_pair,  // Data register pair
  input  wire logic [7:0]            i_sig_byte,   // Signature byte at pointer
  input  wire logic [7:0]            i_fuse_bits,  // Fuse bits
  input  wire logic [7:0]            i_lock_bits,  // Lock bits
  output logic      [7:0]            o_load_data,  // Special load result
  output logic                       o_load_valid, // Special load served
  output logic                       o_cpu_halt,   // Hold CPU
  output logic                       o_flash_ers,  // Start page erase pulse
  output logic                       o_flash_wrt,  // Start page write pulse
  output logic      [PTR_W-AW-2:0]   o_flash_page, // Page being programmed
  input  wire logic                  i_flash_done, // Flash op finished pulse
  input  wire logic [AW-1:0]         i_prog_addr,  // Buffer word the flash reads
  output logic      [15:0]           o_prog_data   // Buffer word, registered
);
  localparam int PG_W = PTR_W - AW - 1; // Page number width

  logic [5:0]                  ctrl_q;    // Control bits 5:0
  spc_pkg::spc_state_type      state_q;   // Idle or programming
  logic [2:0]                  age;       // Cycles since arming
  logic                        wr_hit;    // Write to control register
  logic                        wr_ok;     // Write that takes effect
  logic                        store_open; // Store window open
  logic                        load_open; // Load window open
  logic                        st_arm;    // Store with armed meaning
  logic                        ld_arm;    // Load with armed meaning
  logic                        expired;   // Window ran out
  logic                        is_busy;   // Programming in progress

  spc_buf_if #(.AW(AW)) buf_if ();

  // Page buffer memory
  spc_page_buf #(.AW(AW)) u_buf (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .bus       (buf_if.mem)
  );

  // Arming window counter
  spc_arm_timer u_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_start   (wr_ok),
    .o_age     (age)
  );

  // Access decode; a busy controller ignores new arming
  always_comb begin
    is_busy    = (state_q == spc_pkg::ST_BUSY);
    wr_hit     = i_reg_wr && (i_reg_addr == spc_pkg::CTRL_ADDR);
    wr_ok      = wr_hit && !is_busy && spc_pkg::legal_pat(i_reg_wdata[5:0]);
    store_open = ctrl_q[spc_pkg::BIT_EN] && (age < spc_pkg::STORE_WIN);
    load_open  = ctrl_q[spc_pkg::BIT_EN] && (age < spc_pkg::LOAD_WIN);
    // Outside its window an instruction keeps its ordinary meaning
    st_arm     = i_store_req && store_open && !is_busy && !wr_hit;
    ld_arm     = i_load_req && load_open && !is_busy && !wr_hit &&
                 (ctrl_q[spc_pkg::BIT_SIG] || ctrl_q[spc_pkg::BIT_FUSE_LOCK_READ_ARM]);
    expired    = ctrl_q[spc_pkg::BIT_EN] && (age >= spc_pkg::STORE_WIN);
  end

  // Control bits: arming, completion and timeout
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= spc_pkg::CTRL_RST;
    end else if (i_clk_en) begin
      if (is_busy) begin
        // Enable and op bit stay up until the flash finishes
        if (i_flash_done) begin
          ctrl_q <= spc_pkg::CTRL_RST;
        end
      end else if (wr_ok) begin
        ctrl_q <= i_reg_wdata[5:0];
      end else if (st_arm) begin
        // Erase and write keep their bits through the operation
        if (!(ctrl_q[spc_pkg::BIT_ERS] || ctrl_q[spc_pkg::BIT_WRT])) begin
          ctrl_q <= spc_pkg::CTRL_RST;
        end
      end else if (ld_arm) begin
        ctrl_q <= spc_pkg::CTRL_RST;
      end else if (expired) begin
        ctrl_q <= spc_pkg::CTRL_RST;
      end
    end
  end

  // Operation state: busy from armed erase/write store to done
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= spc_pkg::ST_IDLE;
    end else if (i_clk_en) begin
      unique case (state_q)
        spc_pkg::ST_IDLE: begin
          if (st_arm && (ctrl_q[spc_pkg::BIT_ERS] || ctrl_q[spc_pkg::BIT_WRT])) begin
            state_q <= spc_pkg::ST_BUSY;
          end
        end
        spc_pkg::ST_BUSY: begin
          if (i_flash_done) begin
            state_q <= spc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // CPU halt mirrors the busy state, registered for a clean output
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cpu_halt <= 1'b0;
    end else if (i_clk_en) begin
      if (st_arm && (ctrl_q[spc_pkg::BIT_ERS] || ctrl_q[spc_pkg::BIT_WRT])) begin
        o_cpu_halt <= 1'b1;
      end else if (is_busy && i_flash_done) begin
        o_cpu_halt <= 1'b0;
      end
    end
  end

  // Flash start pulses; the data pair plays no part here
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flash_ers <= 1'b0;
      o_flash_wrt <= 1'b0;
    end else if (i_clk_en) begin
      o_flash_ers <= st_arm && ctrl_q[spc_pkg::BIT_ERS];
      o_flash_wrt <= st_arm && ctrl_q[spc_pkg::BIT_WRT];
    end
  end

  // Page number from the pointer's upper bits, caught at the store
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flash_page <= '0;
    end else if (i_clk_en) begin
      if (st_arm && (ctrl_q[spc_pkg::BIT_ERS] || ctrl_q[spc_pkg::BIT_WRT])) begin
        o_flash_page <= i_ptr[PTR_W-1:AW+1];
      end
    end
  end

  // Buffer fill with plain enable; byte bit of the pointer unused
  always_comb begin
    buf_if.wr    = st_arm && (ctrl_q == spc_pkg::PAT_FILL);
    buf_if.waddr = i_ptr[AW:1];
    buf_if.wdata = i_data_pair;
    // Clear takes effect on the arming write itself
    buf_if.clr   = wr_ok && i_reg_wdata[spc_pkg::BIT_CLEAR_PAGE_BUFFER];
    buf_if.raddr = i_prog_addr;
    o_prog_data  = buf_if.rdata;
  end

  // Special loads: signature byte, or fuse/lock by pointer bit zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_load_data  <= 8'h00;
      o_load_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_load_valid <= ld_arm;
      if (ld_arm && ctrl_q[spc_pkg::BIT_SIG]) begin
        o_load_data <= i_sig_byte;
      end else if (ld_arm) begin
        o_load_data <= i_ptr[0] ? i_lock_bits : i_fuse_bits;
      end
    end
  end

  // Read port; top two bits are constant zero and hold no state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_clk_en) begin
      if (i_reg_rd && (i_reg_addr == spc_pkg::CTRL_ADDR)) begin
        o_reg_rdata <= {spc_pkg::RSV_READ, ctrl_q};
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // One clock domain; the later checks lean on these defaults
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Checks
  a_top_bit_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_reg_rdata[7]) else $error("reserved top bit read as one");

  a_busy_bit_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_reg_rdata[6]) else $error("section busy bit read as one");

  a_sig_load_byte: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && i_load_req && !wr_hit && ctrl_q == spc_pkg::PAT_SIG && age < 3'h3
    |=> o_load_valid && o_load_data == $past(i_sig_byte))
    else $error("signature load not served");

  a_sig_store_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_store_req && ctrl_q[spc_pkg::BIT_SIG] |-> !buf_if.wr
    ##1 !o_flash_ers && !o_flash_wrt) else $error("store acted in signature mode");

  a_clear_on_clear_page_buffer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && wr_hit && !is_busy && i_reg_wdata[5:0] == spc_pkg::PAT_CLEAR_PAGE_BUFFER
    |-> buf_if.clr) else $error("buffer clear missed");

  a_fuse_lock_pick: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && i_load_req && !wr_hit && ctrl_q == spc_pkg::PAT_FUSE_LOCK_READ_ARM && age < 3'h3
    |=> o_load_valid && o_load_data ==
        ($past(i_ptr[0]) ? $past(i_lock_bits) : $past(i_fuse_bits)))
    else $error("fuse/lock selection wrong");

  a_page_wrt_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && !is_busy && !wr_hit && i_store_req && ctrl_q == spc_pkg::PAT_WRT && age < 3'h4
    |=> o_flash_wrt && o_cpu_halt && o_flash_page == $past(i_ptr[PTR_W-1:AW+1]))
    else $error("page write not started");

  a_page_ers_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && !is_busy && !wr_hit && i_store_req && ctrl_q == spc_pkg::PAT_ERS && age < 3'h4
    |=> o_flash_ers && o_cpu_halt) else $error("page erase not started");

  a_timeout_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && !is_busy && !wr_hit && ctrl_q[spc_pkg::BIT_EN] && age == 3'h4
    |=> ctrl_q == 6'h00) else $error("arm bits did not time out");

  a_halt_held: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_busy && !i_flash_done |=> o_cpu_halt && ctrl_q[spc_pkg::BIT_EN])
    else $error("halt or enable dropped during operation");

  a_late_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_store_req && age == 3'h4 |-> !buf_if.wr ##1 !o_flash_wrt && !o_flash_ers)
    else $error("store acted outside window");

  a_fill_word: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && !wr_hit && i_store_req && ctrl_q == spc_pkg::PAT_FILL && age < 3'h4
    |-> buf_if.wr && buf_if.waddr == i_ptr[AW:1] ##1 ctrl_q == 6'h00)
    else $error("buffer fill wrong");

  a_bad_pat_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && wr_hit && !spc_pkg::legal_pat(i_reg_wdata[5:0]) && !ctrl_q[spc_pkg::BIT_EN]
    && !is_busy |=> ctrl_q == 6'h00) else $error("illegal pattern took effect");

  // Each control read shows the live bits with the top two forced low
  a_ctrl_readback: assert property (
    i_clk_en && i_reg_rd && i_reg_addr == spc_pkg::CTRL_ADDR
    |=> o_reg_rdata == {2'b00, $past(ctrl_q)})
    else $error("control read back wrong");

  // Read data fall back to zero, so reserved bits never leak a one
  a_rdata_idle: assert property (
    i_clk_en && !i_reg_rd
    |=> o_reg_rdata == 8'h00)
    else $error("read data without a read");

  // Start pulses last one cycle, or the flash would start twice
  a_ers_single: assert property (
    i_clk_en && o_flash_ers
    |=> !o_flash_ers)
    else $error("erase start held too long");

  // Same for the write start
  a_wrt_single: assert property (
    i_clk_en && o_flash_wrt
    |=> !o_flash_wrt)
    else $error("write start held too long");

  // Legal patterns never arm erase and write together
  a_one_start: assert property (
    !(o_flash_ers && o_flash_wrt))
    else $error("erase and write started together");

  // While busy nothing but completion may touch the control bits
  a_busy_frozen: assert property (
    i_clk_en && is_busy && !i_flash_done
    |=> $stable(ctrl_q))
    else $error("control changed during operation");

  // Completion frees the CPU and drops every arm bit at once
  a_done_release: assert property (
    i_clk_en && is_busy && i_flash_done
    |=> !o_cpu_halt && ctrl_q == 6'h00)
    else $error("operation end not released");

  // Halt follows the busy state exactly; no gap for the CPU to run
  a_halt_is_busy: assert property (
    o_cpu_halt == is_busy)
    else $error("halt and busy state disagree");

  // A load after its short window is an ordinary load
  a_late_load: assert property (
    i_clk_en && i_load_req && age >= 3'h3
    |=> !o_load_valid)
    else $error("late load served as special");

  // Without a read arm a load is never special
  a_unarmed_load: assert property (
    i_clk_en && i_load_req && !ctrl_q[spc_pkg::BIT_SIG] && !ctrl_q[spc_pkg::BIT_FUSE_LOCK_READ_ARM]
    |=> !o_load_valid)
    else $error("unarmed load served as special");

  // Clear or fuse arming gives a store no buffer or flash effect
  a_other_store_idle: assert property (
    i_store_req && (ctrl_q[spc_pkg::BIT_CLEAR_PAGE_BUFFER] || ctrl_q[spc_pkg::BIT_FUSE_LOCK_READ_ARM])
    |-> !buf_if.wr ##1 !o_flash_wrt && !o_flash_ers)
    else $error("store acted under clear or fuse arming");

  // An accepted write restarts the window with exactly the written bits
  a_arm_restart: assert property (
    i_clk_en && wr_ok
    |=> age == 3'h0 && ctrl_q == $past(i_reg_wdata[5:0]))
    else $error("arming write not taken");

  // Control never holds a pattern that software could not arm
  a_ctrl_legal: assert property (
    ctrl_q == spc_pkg::CTRL_RST || spc_pkg::legal_pat(ctrl_q))
    else $error("control holds an illegal pattern");

  // The flash reads the page number for the whole operation
  a_page_held: assert property (
    is_busy
    |=> $stable(o_flash_page))
    else $error("page number moved during operation");

  c_page_write: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_flash_wrt ##[1:20] !o_cpu_halt);
  c_page_erase: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_flash_ers);
  c_sig_read: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_load_valid && $past(ctrl_q[spc_pkg::BIT_SIG]));
  c_fill: cover property (@(posedge i_clk) disable iff (i_sys_rst) buf_if.wr);
  // Enable still up past the store window, lapsed or during an operation
  c_timeout: cover property (expired);
endmodule

// [hw/spc_pkg.sv]
package spc_pkg;
  localparam logic [7:0] CTRL_ADDR  = 8'h00; // Register address
  localparam int         BIT_EN     = 0;     // Enable bit
  localparam int         BIT_ERS    = 1;     // Page erase arm
  localparam int         BIT_WRT    = 2;     // Page write arm
  localparam int         BIT_FUSE_LOCK_READ_ARM   = 3;     // Fuse/lock read arm
  localparam int         BIT_CLEAR_PAGE_BUFFER   = 4;     // Clear page buffer
  localparam int         BIT_SIG    = 5;     // Signature read arm
  localparam logic [5:0] CTRL_RST   = 6'h00; // Control reset value
  localparam logic [1:0] RSV_READ   = 2'h0;  // Bits 7:6 read value
  localparam logic [2:0] STORE_WIN  = 3'h4;  // Store window, cycles
  localparam logic [2:0] LOAD_WIN   = 3'h3;  // Load window, cycles
  localparam logic [5:0] PAT_SIG    = 6'h21; // Legal write patterns
  localparam logic [5:0] PAT_CLEAR_PAGE_BUFFER   = 6'h11;
  localparam logic [5:0] PAT_FUSE_LOCK_READ_ARM   = 6'h09;
  localparam logic [5:0] PAT_WRT    = 6'h05;
  localparam logic [5:0] PAT_ERS    = 6'h03;
  localparam logic [5:0] PAT_FILL   = 6'h01;
  localparam logic [15:0] ERASED_WD = 16'hffff; // Cleared buffer word

  typedef enum logic {ST_IDLE, ST_BUSY} spc_state_type;

  // Accepts only the six documented control patterns
  function automatic logic legal_pat(input logic [5:0] p);
    legal_pat = (p == PAT_SIG) || (p == PAT_CLEAR_PAGE_BUFFER) || (p == PAT_FUSE_LOCK_READ_ARM) ||
                (p == PAT_WRT) || (p == PAT_ERS) || (p == PAT_FILL);
  endfunction
endpackage

// [hw/spc_buf_if.sv]
`timescale 1ns/10ps
// Page buffer access between controller and its memory
interface spc_buf_if #(parameter int AW = 6);
  logic          wr;    // Word write strobe
  logic [AW-1:0] waddr; // Write word index
  logic [15:0]   wdata; // Write data
  logic          clr;   // Clear whole buffer
  logic [AW-1:0] raddr; // Read word index
  logic [15:0]   rdata; // Registered read data
  modport ctl (output wr, waddr, wdata, clr, raddr, input rdata);
  modport mem (input wr, waddr, wdata, clr, raddr, output rdata);
endinterface

// [hw/spc_page_buf.sv]
`timescale 1ns/10ps
// Temporary page buffer; a clear marks all words erased at once
module spc_page_buf #(
  parameter int AW = 6 // Word index width
) (
  input wire logic i_clk,     // Clock
  input wire logic i_sys_rst, // Sync reset
  input wire logic i_clk_en,  // Clock enable
  spc_buf_if.mem   bus        // Buffer port
);
  localparam int N = 1 << AW; // Words in a page

  logic [15:0]  mem_q [N];   // Word storage, no reset needed
  logic [N-1:0] valid_q;     // Word written since last clear

  // Storage; valid bits avoid a many-cycle clear sweep
  always_ff @(posedge i_clk) begin
    if (i_clk_en && bus.wr) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end

  // Valid tracking; clear wins over a same-cycle write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      valid_q <= '0;
    end else if (i_clk_en) begin
      if (bus.clr) begin
        valid_q <= '0;
      end else if (bus.wr) begin
        valid_q[bus.waddr] <= 1'b1;
      end
    end
  end

  // Registered read; unwritten words read as erased flash
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus.rdata <= spc_pkg::ERASED_WD;
    end else if (i_clk_en) begin
      bus.rdata <= valid_q[bus.raddr] ? mem_q[bus.raddr] : spc_pkg::ERASED_WD;
    end
  end
endmodule

// [hw/spc_arm_timer.sv]
`timescale 1ns/10ps
// Counts cycles since the last arming write, saturating
module spc_arm_timer (
  input  wire logic       i_clk,     // Clock
  input  wire logic       i_sys_rst, // Sync reset
  input  wire logic       i_clk_en,  // Clock enable
  input  wire logic       i_start,   // Arming write accepted
  output logic      [2:0] o_age      // Cycles since arming
);
  // Idle at the limit so nothing looks armed after reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_age <= spc_pkg::STORE_WIN;
    end else if (i_clk_en) begin
      if (i_start) begin
        o_age <= 3'h0;
      end else if (o_age < spc_pkg::STORE_WIN) begin
        o_age <= o_age + 3'h1;
      end
    end
  end
endmodule

// [tb/spc_flash_model.sv]
`timescale 1ns/10ps
// Flash macro stand-in: a write reads the whole page buffer, then done
module spc_flash_model #(
  parameter int LAT = 12 // Extra busy cycles per operation
) (
  input  wire logic        i_clk,       // Clock
  input  wire logic        i_ers,       // Erase start pulse
  input  wire logic        i_wrt,       // Write start pulse
  input  wire logic [15:0] i_prog_data, // Buffer word, one cycle late
  output logic      [5:0]  o_prog_addr, // Buffer word wanted
  output logic             o_done       // Operation finished pulse
);
  logic [15:0] img [64]; // Last page image programmed
  int          k;        // Word counter
  logic        is_wr;    // Write, caught at the start pulse
  // One operation at a time; starts seen while busy are not looked at
  initial begin
    o_done      = 1'b0;
    o_prog_addr = 6'h00;
    forever begin
      @(posedge i_clk);
      if (i_wrt === 1'b1 || i_ers === 1'b1) begin
        // The start is a one-cycle pulse, so remember which one it was
        is_wr = (i_wrt === 1'b1);
        // Read data lag the address by one cycle, hence one extra turn
        for (k = 0; k <= 64 && is_wr; k++) begin
          o_prog_addr <= k[5:0];
          @(posedge i_clk);
          if (k > 0) img[k-1] = i_prog_data;
        end
        // Slow answer: the array stays busy a while longer
        repeat (LAT) @(posedge i_clk);
        o_done <= 1'b1;
        @(posedge i_clk);
        o_done <= 1'b0;
      end
    end
  end
endmodule

// [tb/self_program_control_tb.sv]
`timescale 1ns/10ps
// Bench for the self-programming controller, flash stand-in beside it
module self_program_control_tb;
  logic        i_clk      = 1'b0;     // 50 MHz clock
  logic        i_sys_rst  = 1'b1;     // Sync reset
  logic [7:0]  reg_addr   = 8'h00;    // Register bus
  logic [7:0]  reg_wdata  = 8'h00;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [7:0]  reg_rdata;
  logic        store_req  = 1'b0;     // CPU side
  logic        load_req   = 1'b0;
  logic [15:0] ptr        = 16'h0000;
  logic [15:0] data_pair  = 16'h0000;
  logic [7:0]  sig_byte   = 8'h00;
  logic [7:0]  fuse_bits  = 8'h00;
  logic [7:0]  lock_bits  = 8'h00;
  logic [7:0]  load_data;
  logic        load_valid;
  logic        cpu_halt;
  logic        flash_ers;
  logic        flash_wrt;
  logic [8:0]  flash_page;
  logic        flash_done;
  logic [5:0]  prog_addr;
  logic [15:0] prog_data;
  logic [15:0] lfsr       = 16'h62fa; // Fixed seed
  logic [15:0] r;                     // Scratch random
  logic [5:0]  v;                     // Control pattern
  logic        saw;                   // Done pulse seen
  logic [5:0]  pats [5] = '{spc_pkg::PAT_SIG, spc_pkg::PAT_FUSE_LOCK_READ_ARM, spc_pkg::PAT_WRT,
                            spc_pkg::PAT_ERS, spc_pkg::PAT_FILL};
  int          buf_m [64];            // Reference page buffer
  int          mismatches   = 0;
  int          total_checks = 0;
  int          i;
  int          n;

  always #10 i_clk = ~i_clk;

  spc_ctrl #(.PTR_W(16), .AW(6)) i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_store_req(store_req),
    .i_load_req(load_req), .i_ptr(ptr), .i_data_pair(data_pair),
    .i_sig_byte(sig_byte), .i_fuse_bits(fuse_bits), .i_lock_bits(lock_bits),
    .o_load_data(load_data), .o_load_valid(load_valid), .o_cpu_halt(cpu_halt),
    .o_flash_ers(flash_ers), .o_flash_wrt(flash_wrt), .o_flash_page(flash_page),
    .i_flash_done(flash_done), .i_prog_addr(prog_addr), .o_prog_data(prog_data));

  spc_flash_model #(.LAT(12)) i_fm (
    .i_clk(i_clk), .i_ers(flash_ers), .i_wrt(flash_wrt),
    .i_prog_data(prog_data), .o_prog_addr(prog_addr), .o_done(flash_done));

  // Galois-free shift register, so the run repeats exactly
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Every task starts just after an edge and returns just after one
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
  endtask

  task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    @(posedge i_clk);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic store(input logic [15:0] p, input logic [15:0] d);
    ptr       <= p;
    data_pair <= d;
    store_req <= 1'b1;
    @(posedge i_clk);
    store_req <= 1'b0;
  endtask

  task automatic load_chk(input logic [15:0] p, input logic vld, input logic [7:0] d);
    ptr      <= p;
    load_req <= 1'b1;
    @(posedge i_clk);
    load_req <= 1'b0;
    @(posedge i_clk);
    chk({15'h0000, load_valid}, {15'h0000, vld});
    if (vld) chk({8'h00, load_data}, {8'h00, d});
  endtask

  // Arm a buffer fill, wait g cycles, store; late stores change nothing
  task automatic fill(input int w, input logic [15:0] d, input int g);
    reg_wr_t(8'h00, {2'b00, spc_pkg::PAT_FILL});
    idle(g);
    r = rnd();
    store({9'h0a5, w[5:0], r[0]}, d);
    if (g < 4) buf_m[w] = d;
  endtask

  // Erase or page write; one store in flight at a time
  task automatic op(input logic [5:0] pat, input logic [8:0] pg, input logic wr);
    reg_wr_t(8'h00, {2'b00, pat});
    store({pg, 7'h55}, rnd());
    idle(1);
    chk({15'h0000, flash_wrt}, {15'h0000, wr});
    chk({15'h0000, flash_ers}, {15'h0000, !wr});
    chk({7'h00, flash_page}, {7'h00, pg});
    chk({15'h0000, cpu_halt}, 16'h0001);
    rd_chk(8'h00, {2'b00, pat});
    saw = 1'b0;
    n = 0;
    while (cpu_halt !== 1'b0 && n < 400) begin
      if (flash_done === 1'b1) saw = 1'b1;
      @(posedge i_clk);
      n++;
    end
    chk({15'h0000, saw}, 16'h0001);
    rd_chk(8'h00, 8'h00);
  endtask

  // Compare the programmed image with the reference buffer
  task automatic img_chk();
    for (i = 0; i < 64; i++) chk(i_fm.img[i], buf_m[i][15:0]);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    summarize();
  end

  initial begin
    for (i = 0; i < 64; i++) buf_m[i] = 16'hffff;
    idle(5);
    i_sys_rst <= 1'b0;
    r = rnd();
    fuse_bits <= r[7:0];
    lock_bits <= r[15:8];
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    // Five legal patterns, all but clear, read back without top bits; others are dropped
    for (i = 0; i < 9; i++) begin
      r = rnd();
      v = (i < 5) ? pats[i] : {2'b11, r[3:0]};
      reg_wr_t(8'h00, {2'b11, v});
      rd_chk(8'h00, (i < 5) ? {2'b00, v} : 8'h00);
      idle(6);
      rd_chk(8'h00, 8'h00);
    end
    // Store after a timed-out page write arming acts ordinarily
    reg_wr_t(8'h00, {2'b00, spc_pkg::PAT_WRT});
    idle(4);
    store(16'h0380, 16'h1234);
    idle(1);
    chk({15'h0000, flash_wrt | flash_ers | cpu_halt}, 16'h0000);
    // Fill every word with gaps 0..4 cycles, gap-4 words staying erased, then program the page
    for (n = 0; n < 64; n++) fill(n, rnd(), n % 5);
    op(spc_pkg::PAT_WRT, 9'h0a5, 1'b1);
    img_chk();
    // Clear while filling, refill one word, program again
    fill(3, rnd(), 0);
    reg_wr_t(8'h00, {2'b00, spc_pkg::PAT_CLEAR_PAGE_BUFFER});
    idle(6);
    for (i = 0; i < 64; i++) buf_m[i] = 16'hffff;
    fill(7, rnd(), 1);
    op(spc_pkg::PAT_WRT, 9'h1f0, 1'b1);
    img_chk();
    r = rnd();
    op(spc_pkg::PAT_ERS, r[8:0], 1'b0);
    // Signature loads at ages 0..3; the last one is too late
    for (i = 0; i < 4; i++) begin
      r = rnd();
      sig_byte <= r[7:0];
      reg_wr_t(8'h00, {2'b00, spc_pkg::PAT_SIG});
      idle(i);
      load_chk({r[15:1], 1'b0}, i < 3, r[7:0]);
      idle(6);
    end
    // Fuse or lock chosen by pointer bit zero
    for (i = 0; i < 4; i++) begin
      reg_wr_t(8'h00, {2'b00, spc_pkg::PAT_FUSE_LOCK_READ_ARM});
      idle(2 * (i / 2));
      load_chk({15'h0040, i[0]}, 1'b1, i[0] ? lock_bits : fuse_bits);
      idle(6);
    end
    // A store after signature arming starts nothing and drops the arm bits
    reg_wr_t(8'h00, {2'b00, spc_pkg::PAT_SIG});
    store(16'h0380, rnd());
    idle(1);
    chk({15'h0000, flash_wrt | flash_ers | cpu_halt}, 16'h0000);
    rd_chk(8'h00, 8'h00);
    summarize();
  end
endmodule
